// ### logic/dram_host_regs.vh
/*
 * Constants for the DRAM calibration, termination and bank access controller:
 * register offsets, field positions, command codes and timing counts.
 * Assumes a 40 ns reference clock; every count below is in reference clock cycles.
 */
`ifndef DRAM_HOST_REGS_VH
`define DRAM_HOST_REGS_VH

// Register offsets.
`define REG_CMD          5'h00
`define REG_ADDR         5'h04
`define REG_CTRL         5'h08
`define REG_STAT         5'h0c

// Command register fields.
`define CMD_OP_LSB       0
`define CMD_BANK_LSB     4
`define CMD_AUTOPRE_BIT  6
`define CMD_CAL_LSB      7
`define CMD_CODE_LSB     10

// Command codes.
`define OP_ACT           3'h0
`define OP_READ          3'h1
`define OP_WRITE         3'h2
`define OP_PRE           3'h3
`define OP_MODE          3'h4
`define OP_EXT1          3'h5

// Calibration field values.
`define CAL_EXIT         3'h0
`define CAL_DRIVE_HIGH   3'h1
`define CAL_DRIVE_LOW    3'h2
`define CAL_ADJUST       3'h4
`define CAL_DEFAULT      3'h7

// Mode register and extended register one fields.
`define MODE_BL_LSB      0
`define MODE_BL4         3'h2
`define MODE_CL_LSB      4
`define EXT1_AL_LSB      3
`define EXT1_CAL_LSB     7

// Status register fields.
`define STAT_BUSY_BIT    0
`define STAT_ERR_BIT     1
`define STAT_OPEN_LSB    2
`define STAT_BL4_BIT     6
`define STAT_DQ_HI_BIT   7
`define STAT_DQ_LO_BIT   8

// Timing figures in ns and derived cycle counts (least times round up).
`define CLK_NS           40
`define T_RC_NS          55
`define T_RRD_NS         10
`define T_RCD_NS         15
`define T_AOFD_NS        100
`define T_MOD_MAX_NS     12
`define T_OIT_NS         12
`define T_RC_CYC         ((`T_RC_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RRD_CYC        ((`T_RRD_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RCD_CYC        ((`T_RCD_NS + `CLK_NS - 1) / `CLK_NS)
`define T_AOFD_CYC       ((`T_AOFD_NS + `CLK_NS - 1) / `CLK_NS)
`define T_MOD_CYC        ((`T_MOD_MAX_NS + `CLK_NS - 1) / `CLK_NS)
`define T_OIT_CYC        ((`T_OIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### logic/dram_host.v
/*
 * Host-side controller for a four-bank DDR2 DRAM: bank activate, read, write and
 * precharge commands, mode register writes, driver impedance calibration and
 * termination value updates. Software reaches it over a plain register port.
 * Assumes the DRAM samples commands on the rising edge of mem_ck, which this
 * block makes by halving ref_clk. The write and read data paths are outside
 * this block; only the adjust code burst is driven here.
 */
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "dram_host_regs.vh"

module dram_host #(
    parameter [7:0] DRIVE_HOLD_CYC = 8'h10
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // Software register port
    input  wire [4:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    // DRAM command pins
    output wire        mem_ck,
    output wire        mem_cke,
    output wire        mem_cs_n,
    output wire        mem_ras_n,
    output wire        mem_cas_n,
    output wire        mem_we_n,
    output wire [1:0]  mem_ba,
    output wire [12:0] mem_a,
    output wire        mem_odt,
    // DRAM data lines
    output wire [15:0] mem_dq_o,
    output wire        mem_dq_oe,
    input  wire [15:0] mem_dq_i
);

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_AOFD  = 3'h1;
    localparam [2:0] S_ISSUE = 3'h2;
    localparam [2:0] S_HOLD  = 3'h3;
    localparam [2:0] S_WAIT  = 3'h4;
    localparam [2:0] S_BURST = 3'h5;

    localparam [1:0] P_DONE = 2'h0;
    localparam [1:0] P_EXIT = 2'h1;
    localparam [1:0] P_ADJ  = 2'h2;

    localparam [31:0] TRC_W  = `T_RC_CYC;
    localparam [31:0] TRRD_W = `T_RRD_CYC;
    localparam [31:0] TRCD_W = `T_RCD_CYC;
    localparam [31:0] AOFD_W = `T_AOFD_CYC;
    localparam [31:0] MOD_W  = `T_MOD_CYC;
    localparam [31:0] OIT_W  = `T_OIT_CYC;

    reg        ck_ff;
    reg        cke_ff;
    reg        cs_n_ff;
    reg        ras_n_ff;
    reg        cas_n_ff;
    reg        we_n_ff;
    reg [1:0]  ba_ff;
    reg [12:0] a_ff;
    reg        odt_ff;
    reg [15:0] dq_o_ff;
    reg        dq_oe_ff;
    reg [31:0] rdata_ff;
    reg [15:0] dq_s1_ff;
    reg [15:0] dq_s2_ff;

    reg [2:0]  state_ff;
    reg [1:0]  post_ff;
    reg [7:0]  timer_ff;
    reg [2:0]  beat_ff;
    reg [2:0]  op_ff;
    reg [1:0]  bank_ff;
    reg        ap_ff;
    reg [2:0]  cal_ff;
    reg [3:0]  code_ff;
    reg [12:0] addr_ff;
    reg        odt_en_ff;
    reg        cke_en_ff;
    reg        odt_hold_ff;
    reg        err_ff;
    reg        bl4_ff;
    reg [2:0]  cl_ff;
    reg [2:0]  al_ff;
    reg [5:0]  rrd_ff;
    reg [5:0]  since_act_ff [0:3];
    reg [3:0]  open_ff;

    wire       cmd_wr   = reg_wr && (reg_addr == `REG_CMD);
    wire [2:0] w_op     = reg_wdata[`CMD_OP_LSB +: 3];
    wire [1:0] w_bank   = reg_wdata[`CMD_BANK_LSB +: 2];
    wire [2:0] w_cal    = reg_wdata[`CMD_CAL_LSB +: 3];
    wire [3:0] w_code   = reg_wdata[`CMD_CODE_LSB +: 4];
    wire       fire     = (state_ff == S_ISSUE) && ck_ff;
    wire [7:0] w_since  = {2'h0, since_act_ff[w_bank]};
    wire [7:0] al2      = {4'h0, al_ff, 1'b0};
    wire [7:0] wl2      = {3'h0, al_ff + cl_ff - 3'h1, 1'b0} - 8'h2;
    reg        cal_ok;
    reg        code_ok;
    reg        accept;

    always @* begin
        case (w_cal)
            `CAL_EXIT, `CAL_DRIVE_HIGH, `CAL_DRIVE_LOW, `CAL_ADJUST, `CAL_DEFAULT: cal_ok = 1'b1;
            default: cal_ok = 1'b0;
        endcase
        case (w_code)
            4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha: code_ok = 1'b1;
            default: code_ok = 1'b0;
        endcase
        case (w_op)
            `OP_ACT:   accept = !open_ff[w_bank] && (w_since >= TRC_W[7:0])
                                && ({2'h0, rrd_ff} >= TRRD_W[7:0]);
            `OP_READ,
            `OP_WRITE: accept = open_ff[w_bank] && ((w_since + al2) >= TRCD_W[7:0]);
            `OP_PRE:   accept = 1'b1;
            `OP_MODE:  accept = (open_ff == 4'h0);
            `OP_EXT1:  accept = (open_ff == 4'h0) && cal_ok
                                && ((w_cal != `CAL_ADJUST) || (bl4_ff && code_ok));
            default:   accept = 1'b0;
        endcase
    end

    // Per-bank activate age and open state; ages saturate so an idle bank is always ready.
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_bank
            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    since_act_ff[b] <= 6'h3f;
                    open_ff[b]      <= 1'b0;
                end else if (fire && (bank_ff == b)) begin
                    case (op_ff)
                        `OP_ACT: begin
                            since_act_ff[b] <= 6'h00;
                            open_ff[b]      <= 1'b1;
                        end
                        `OP_PRE: open_ff[b] <= 1'b0;
                        `OP_READ, `OP_WRITE: begin
                            if (ap_ff)
                                open_ff[b] <= 1'b0;
                            if (since_act_ff[b] != 6'h3f)
                                since_act_ff[b] <= since_act_ff[b] + 6'h01;
                        end
                        default: begin
                            if (since_act_ff[b] != 6'h3f)
                                since_act_ff[b] <= since_act_ff[b] + 6'h01;
                        end
                    endcase
                end else if (since_act_ff[b] != 6'h3f) begin
                    since_act_ff[b] <= since_act_ff[b] + 6'h01;
                end
            end
        end
    endgenerate

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rrd_ff <= 6'h3f;
        end else if (fire && (op_ff == `OP_ACT)) begin
            rrd_ff <= 6'h00;
        end else if (rrd_ff != 6'h3f) begin
            rrd_ff <= rrd_ff + 6'h01;
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dq_s1_ff <= 16'h0000;
            dq_s2_ff <= 16'h0000;
            rdata_ff <= 32'h0000_0000;
        end else begin
            dq_s1_ff <= mem_dq_i;
            dq_s2_ff <= dq_s1_ff;
            rdata_ff <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `REG_CMD:  rdata_ff <= {18'h0, code_ff, cal_ff, ap_ff, bank_ff, 1'b0, op_ff};
                    `REG_ADDR: rdata_ff <= {19'h0, addr_ff};
                    `REG_CTRL: rdata_ff <= {30'h0, cke_en_ff, odt_en_ff};
                    `REG_STAT: rdata_ff <= {23'h0, (dq_s2_ff == 16'h0000), (dq_s2_ff == 16'hffff),
                                            bl4_ff, open_ff, err_ff, (state_ff != S_IDLE)};
                    default:   rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Error flag: a refusal in the same cycle as a write-one-to-clear keeps the flag set.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            err_ff <= 1'b0;
        else if (cmd_wr && ((state_ff != S_IDLE) || !accept))
            err_ff <= 1'b1;
        else if (reg_wr && (reg_addr == `REG_STAT) && reg_wdata[`STAT_ERR_BIT])
            err_ff <= 1'b0;
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ck_ff     <= 1'b0;
            cke_ff    <= 1'b0;
            odt_ff    <= 1'b0;
            addr_ff   <= 13'h0000;
            odt_en_ff <= 1'b0;
            cke_en_ff <= 1'b0;
        end else begin
            ck_ff  <= ~ck_ff;
            cke_ff <= cke_en_ff | odt_hold_ff;
            // Termination stays low from the start of an update until tMOD max has passed.
            odt_ff <= odt_en_ff & ~odt_hold_ff;
            if (reg_wr && (reg_addr == `REG_ADDR) && (state_ff == S_IDLE))
                addr_ff <= reg_wdata[12:0];
            if (reg_wr && (reg_addr == `REG_CTRL)) begin
                odt_en_ff <= reg_wdata[0];
                cke_en_ff <= reg_wdata[1];
            end
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff    <= S_IDLE;
            post_ff     <= P_DONE;
            timer_ff    <= 8'h00;
            beat_ff     <= 3'h0;
            op_ff       <= `OP_PRE;
            bank_ff     <= 2'h0;
            ap_ff       <= 1'b0;
            cal_ff      <= `CAL_EXIT;
            code_ff     <= 4'h0;
            odt_hold_ff <= 1'b0;
            bl4_ff      <= 1'b0;
            cl_ff       <= 3'h3;
            al_ff       <= 3'h0;
            cs_n_ff     <= 1'b1;
            ras_n_ff    <= 1'b1;
            cas_n_ff    <= 1'b1;
            we_n_ff     <= 1'b1;
            ba_ff       <= 2'h0;
            a_ff        <= 13'h0000;
            dq_o_ff     <= 16'h0000;
            dq_oe_ff    <= 1'b0;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    if (cmd_wr && accept) begin
                        op_ff   <= w_op;
                        bank_ff <= w_bank;
                        ap_ff   <= reg_wdata[`CMD_AUTOPRE_BIT];
                        cal_ff  <= w_cal;
                        code_ff <= w_code;
                        if (w_op == `OP_EXT1) begin
                            odt_hold_ff <= 1'b1;
                            timer_ff    <= AOFD_W[7:0];
                            state_ff    <= S_AOFD;
                        end else begin
                            state_ff <= S_ISSUE;
                        end
                    end
                end
                S_AOFD: begin
                    if (timer_ff != 8'h00)
                        timer_ff <= timer_ff - 8'h01;
                    else
                        state_ff <= S_ISSUE;
                end
                S_ISSUE: begin
                    // Pins change while mem_ck falls and stand a whole mem_ck cycle, centred on its rise.
                    if (ck_ff) begin
                        cs_n_ff  <= 1'b0;
                        ba_ff    <= bank_ff;
                        a_ff     <= addr_ff;
                        state_ff <= S_HOLD;
                        case (op_ff)
                            `OP_ACT: begin
                                {ras_n_ff, cas_n_ff, we_n_ff} <= 3'b011;
                            end
                            `OP_READ, `OP_WRITE: begin
                                {ras_n_ff, cas_n_ff} <= 2'b10;
                                we_n_ff <= (op_ff == `OP_READ);
                                a_ff    <= {2'h0, ap_ff, 1'b0, addr_ff[8:0]};
                            end
                            `OP_PRE: begin
                                {ras_n_ff, cas_n_ff, we_n_ff} <= 3'b010;
                                a_ff <= 13'h0000;
                            end
                            `OP_MODE: begin
                                {ras_n_ff, cas_n_ff, we_n_ff} <= 3'b000;
                                ba_ff  <= 2'h0;
                                bl4_ff <= (addr_ff[`MODE_BL_LSB +: 3] == `MODE_BL4);
                                cl_ff  <= addr_ff[`MODE_CL_LSB +: 3];
                            end
                            default: begin
                                {ras_n_ff, cas_n_ff, we_n_ff} <= 3'b000;
                                ba_ff <= 2'h1;
                                // Termination value rides in bits 2 and 6 of the stored word.
                                a_ff  <= {addr_ff[12:10], cal_ff, addr_ff[6:0]};
                                if (cal_ff != `CAL_ADJUST)
                                    al_ff <= addr_ff[`EXT1_AL_LSB +: 3];
                            end
                        endcase
                    end
                end
                S_HOLD: if (ck_ff) begin
                    {cs_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 4'hf;
                    state_ff <= S_WAIT;
                    if (op_ff != `OP_EXT1) begin
                        state_ff <= S_IDLE;
                    end else if ((cal_ff == `CAL_DRIVE_HIGH) || (cal_ff == `CAL_DRIVE_LOW)) begin
                        timer_ff <= OIT_W[7:0] + DRIVE_HOLD_CYC;
                        post_ff  <= P_EXIT;
                    end else if (cal_ff == `CAL_ADJUST) begin
                        timer_ff <= wl2;
                        post_ff  <= P_ADJ;
                    end else if (cal_ff == `CAL_DEFAULT) begin
                        timer_ff <= MOD_W[7:0];
                        post_ff  <= P_EXIT;
                    end else begin
                        timer_ff <= MOD_W[7:0];
                        post_ff  <= P_DONE;
                    end
                end
                S_WAIT: begin
                    if (timer_ff != 8'h00) begin
                        timer_ff <= timer_ff - 8'h01;
                    end else if (post_ff == P_ADJ) begin
                        dq_o_ff  <= {16{code_ff[3]}};
                        dq_oe_ff <= 1'b1;
                        beat_ff  <= 3'h1;
                        state_ff <= S_BURST;
                    end else if (post_ff == P_EXIT) begin
                        cal_ff   <= `CAL_EXIT;
                        state_ff <= S_ISSUE;
                    end else begin
                        odt_hold_ff <= 1'b0;
                        state_ff    <= S_IDLE;
                    end
                end
                S_BURST: begin
                    if (beat_ff == 3'h4) begin
                        dq_oe_ff <= 1'b0;
                        cal_ff   <= `CAL_EXIT;
                        state_ff <= S_ISSUE;
                    end else begin
                        dq_o_ff <= {16{code_ff[3 - beat_ff[1:0]]}};
                        beat_ff <= beat_ff + 3'h1;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;
    assign mem_ck    = ck_ff;
    assign mem_cke   = cke_ff;
    assign mem_cs_n  = cs_n_ff;
    assign mem_ras_n = ras_n_ff;
    assign mem_cas_n = cas_n_ff;
    assign mem_we_n  = we_n_ff;
    assign mem_ba    = ba_ff;
    assign mem_a     = a_ff;
    assign mem_odt   = odt_ff;
    assign mem_dq_o  = dq_o_ff;
    assign mem_dq_oe = dq_oe_ff;

endmodule // dram_host

// ### verification/dram_host_asserts.sv
/* Port checker for the DRAM command controller.
   Assumes it is bound to dram_host and sees only that module's pins. */
`timescale 1ns/1ps
module dram_host_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // DRAM pins
    input wire logic        mem_ck,
    input wire logic        mem_cke,
    input wire logic        mem_cs_n,
    input wire logic        mem_ras_n,
    input wire logic        mem_cas_n,
    input wire logic        mem_we_n,
    input wire logic [1:0]  mem_ba,
    input wire logic [12:0] mem_a,
    input wire logic        mem_odt,
    input wire logic [15:0] mem_dq_o,
    input wire logic        mem_dq_oe
);
    wire ext1 = !mem_cs_n && !mem_ras_n && !mem_cas_n && !mem_we_n && mem_ba == 2'h1;
    wire cmd_on = !mem_cs_n;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_cmd_two_cycles: assert property ($fell(mem_cs_n) |=> !mem_cs_n ##1 mem_cs_n)
        else $error("command not held for exactly two cycles");
    chk_cmd_ck_rise: assert property ($fell(mem_cs_n) |-> !mem_ck ##1 mem_ck)
        else $error("command not centred on a rising memory clock");
    chk_cmd_code_legal: assert property (cmd_on |-> {mem_ras_n, mem_cas_n, mem_we_n} inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5})
        else $error("undefined command code on the pins");
    chk_cal_field_legal: assert property (ext1 |-> mem_a[9:7] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7})
        else $error("reserved calibration field sent");
    chk_odt_quiet: assert property ($fell(mem_cs_n) && ext1 |-> !$past(mem_odt, 2) ##0 !mem_odt [*3])
        else $error("termination pin high around a termination update");
    chk_cke_update: assert property ($fell(mem_cs_n) && ext1 |-> mem_cke [*3])
        else $error("clock enable low in the update window");
    chk_code_beats: assert property ($rose(mem_dq_oe) |-> mem_dq_oe [*4] ##1 !mem_dq_oe)
        else $error("adjust code burst is not four beats");
    chk_code_all_lines: assert property (mem_dq_oe |-> mem_dq_o == 16'h0000 || mem_dq_o == 16'hffff)
        else $error("adjust code differs between data lines");

    cov_activate: cover property ($fell(mem_cs_n) && mem_ras_n == 1'b0 && mem_cas_n == 1'b1);
    cov_ext1: cover property ($fell(mem_cs_n) && ext1);
    cov_burst: cover property ($rose(mem_dq_oe));
endmodule // dram_host_chk

// ### verification/dev_model.sv
/* Behavioural DRAM device facing the controller.
   Assumes commands are sampled on rising mem_ck; bank, mode register and termination state and the data lines are modelled. */
`timescale 1ns/1ps
module dev_model #(
    parameter int OIT_CK = 1
) (
    // Command pins
    input wire logic        mem_ck,
    input wire logic        mem_cke,
    input wire logic        mem_cs_n,
    input wire logic        mem_ras_n,
    input wire logic        mem_cas_n,
    input wire logic        mem_we_n,
    input wire logic [1:0]  mem_ba,
    input wire logic [12:0] mem_a,
    input wire logic        mem_odt,
    // Data lines
    input wire logic [15:0] mem_dq_o,
    input wire logic        mem_dq_oe,
    output logic [15:0]     mem_dq_i
);
    logic [17:0] cmd_log = 18'h0;
    logic [3:0]  open_bank = 4'h0, beats = 4'h0, pu = 4'h8, pd = 4'h8;
    logic [2:0]  al = 3'h0, cl = 3'h3, term_sw;
    logic [1:0]  rtt = 2'h0, drv_tgt = 2'h0, drv_now = 2'h0;
    logic        strobe_dis = 1'b0, self_ref = 1'b0, adj_on = 1'b0;
    logic        termination_switch_a, termination_switch_b, termination_switch_c;
    logic [15:0] idle_pat = 16'h5a5a;
    int          cmd_cnt = 0, oit_cnt = 0, ck_adj = 0, nbeat = 0, adj_lat = 0;

    function automatic logic [3:0] step(input logic [3:0] v, input logic up);
        return up ? (v == 4'hf ? v : v + 4'h1) : (v == 4'h0 ? v : v - 4'h1);
    endfunction

    // Released lines flip on every rising mem_ck edge so a stale value never passes for driven data.
    assign mem_dq_i = drv_now == 2'h1 ? 16'hffff : (drv_now == 2'h2 ? 16'h0000 : idle_pat);
    // Complementary strobes would follow strobe_dis; they have no pin here.
    assign termination_switch_a = mem_odt && !self_ref && rtt == 2'h1;
    assign termination_switch_b = mem_odt && !self_ref && rtt == 2'h2;
    assign termination_switch_c = mem_odt && !self_ref && rtt == 2'h3;
    assign term_sw = {termination_switch_c, termination_switch_b, termination_switch_a};

    always @(posedge mem_ck) begin
        idle_pat <= ~idle_pat;
        ck_adj = ck_adj + 1;
        if (oit_cnt > 0 && --oit_cnt == 0) drv_now <= drv_tgt;
        if (!mem_cs_n) begin
            cmd_log = {mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_a};
            cmd_cnt++;
            case ({mem_ras_n, mem_cas_n, mem_we_n})
                3'h3: open_bank[mem_ba] = 1'b1;
                3'h4, 3'h5: if (mem_a[10]) open_bank[mem_ba] = 1'b0;
                3'h2: open_bank[mem_ba] = 1'b0;
                3'h1: self_ref = !mem_cke;
                3'h0: if (mem_ba == 2'h0) cl = mem_a[6:4];
                      else if (mem_ba == 2'h1) begin
                    rtt = {mem_a[6], mem_a[2]};
                    strobe_dis = mem_a[10];
                    if (mem_a[9:7] != 3'h4) al = mem_a[5:3];
                    case (mem_a[9:7])
                        3'h0, 3'h1, 3'h2: begin drv_tgt = mem_a[8:7]; oit_cnt = OIT_CK; end
                        3'h4: begin adj_on = 1'b1; nbeat = 0; ck_adj = 0; end
                        3'h7: begin pu = 4'h8; pd = 4'h8; end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // Sampling a little after each edge keeps clear of the launching edge.
    always @(mem_ck) begin
        #10;
        if (adj_on && mem_dq_oe) begin
            if (nbeat == 0) adj_lat = ck_adj;
            beats = {beats[2:0], mem_dq_o[0]};
            if (++nbeat == 4) begin
                adj_on = 1'b0;
                if (beats inside {4'h1, 4'h5, 4'h9}) pu = step(pu, 1'b1);
                if (beats inside {4'h2, 4'h6, 4'ha}) pu = step(pu, 1'b0);
                if (beats inside {4'h4, 4'h5, 4'h6}) pd = step(pd, 1'b1);
                if (beats inside {4'h8, 4'h9, 4'ha}) pd = step(pd, 1'b0);
            end
        end
    end
endmodule // dev_model

// ### verification/dram_host_tb.sv
/* Self-checking bench for dram_host with a behavioural device on its pins.
   Assumes the register map and timing of the controller's constants header. */
`timescale 1ns/1ps
`include "dram_host_regs.vh"
module dram_host_tb;
    logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0]  reg_addr = 5'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
    logic        mem_ck, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_odt, mem_dq_oe;
    logic [1:0]  mem_ba;
    logic [12:0] mem_a;
    logic [15:0] mem_dq_o, mem_dq_i;
    int          err_total = 0, comparisons = 0, cycles = 0, cnt0 = 0;

    dram_host #(.DRIVE_HOLD_CYC(8'h10)) dram_host_inst (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_ck(mem_ck),
        .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
        .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_a(mem_a), .mem_odt(mem_odt), .mem_dq_o(mem_dq_o),
        .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));
    dev_model #(.OIT_CK(1)) dev_model_inst (.mem_ck(mem_ck), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n),
        .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_a(mem_a),
        .mem_odt(mem_odt), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    // Busy is polled under a bound so a stuck sequencer ends as a mismatch.
    task automatic issue(input logic [2:0] op, input logic [1:0] bk, input logic ap, input logic [2:0] cal,
                         input logic [3:0] code, input logic [12:0] addr);
        int n;
        cnt0 = dev_model_inst.cmd_cnt;
        wr(`REG_ADDR, {19'h0, addr});
        wr(`REG_CMD, {18'h0, code, cal, ap, bk, 1'b0, op});
        n = 0;
        rd(`REG_STAT);
        while (rd_val[`STAT_BUSY_BIT] !== 1'b0 && n < 200) begin
            rd(`REG_STAT);
            n++;
        end
        check(n < 200, 1);
    endtask

    task automatic refused();
        rd(`REG_STAT);
        check({rd_val[`STAT_ERR_BIT], dev_model_inst.cmd_cnt[30:0]}, {1'b1, cnt0[30:0]});
        wr(`REG_STAT, 32'h2);
        rd(`REG_STAT);
        check(rd_val[`STAT_ERR_BIT], 0);
    endtask

    task automatic t_access();
        rd(`REG_STAT);
        check(rd_val[6:0], 7'h0);
        rd(5'h10);
        check(rd_val, 32'h0);
        issue(`OP_ACT, 2'h1, 1'b0, 3'h0, 4'h0, 13'h1abc);
        check(dev_model_inst.cmd_log, {3'h3, 2'h1, 13'h1abc});
        issue(`OP_READ, 2'h1, 1'b1, 3'h0, 4'h0, 13'h01f5);
        check(dev_model_inst.cmd_log, {3'h5, 2'h1, 13'h05f5});
        rd(`REG_STAT);
        check(rd_val[5:2], 4'h0);
        issue(`OP_WRITE, 2'h1, 1'b0, 3'h0, 4'h0, 13'h0003);
        refused();
        issue(`OP_ACT, 2'h2, 1'b0, 3'h0, 4'h0, 13'h0007);
        issue(`OP_ACT, 2'h2, 1'b0, 3'h0, 4'h0, 13'h0007);
        refused();
        issue(`OP_WRITE, 2'h2, 1'b0, 3'h0, 4'h0, 13'h0003);
        check(dev_model_inst.cmd_log, {3'h4, 2'h2, 13'h0003});
        rd(`REG_STAT);
        check(rd_val[5:2], 4'h4);
        issue(`OP_PRE, 2'h2, 1'b0, 3'h0, 4'h0, 13'h0000);
    endtask

    task automatic t_drive();
        logic seen;
        wr(`REG_CTRL, 32'h3);
        issue(`OP_MODE, 2'h0, 1'b0, 3'h0, 4'h0, 13'h0032);
        rd(`REG_STAT);
        check(rd_val[`STAT_BL4_BIT], 1);
        for (int c = 1; c <= 2; c++) begin
            seen = 1'b0;
            wr(`REG_ADDR, 32'h4);
            wr(`REG_CMD, {22'h0, c[2:0], 7'h05});
            for (int n = 0; n < 30; n++) begin
                rd(`REG_STAT);
                if (rd_val[6 + c] === 1'b1) seen = 1'b1;
            end
            issue(`OP_PRE, 2'h0, 1'b0, 3'h0, 4'h0, 13'h0000);
            check(seen, 1);
            check(dev_model_inst.term_sw, 3'h1);
        end
    endtask

    task automatic t_adjust();
        issue(`OP_EXT1, 2'h0, 1'b0, `CAL_EXIT, 4'h0, 13'h000c);
        issue(`OP_EXT1, 2'h0, 1'b0, `CAL_ADJUST, 4'h5, 13'h0004);
        check({dev_model_inst.pu, dev_model_inst.pd}, 8'h99);
        check(dev_model_inst.beats, 4'h5);
        check(dev_model_inst.adj_lat, 3);
        check(dev_model_inst.cmd_log[9:7], 3'h0);
        issue(`OP_EXT1, 2'h0, 1'b0, `CAL_ADJUST, 4'h3, 13'h0004);
        refused();
        issue(`OP_EXT1, 2'h0, 1'b0, 3'h3, 4'h0, 13'h0004);
        refused();
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_access();
        t_drive();
        t_adjust();
        give_verdict();
    end
endmodule // dram_host_tb

bind dram_host dram_host_chk dram_host_chk_inst (.ref_clk(ref_clk), .rstn(rstn), .mem_ck(mem_ck),
    .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_a(mem_a), .mem_odt(mem_odt), .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe));
